/* File: src/bit_pkg.sv */
package bit_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8b;
    localparam logic [7:0] ADDR_COUNT_VALUE = 8'h8c;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h8d;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h8e;

    // ==========================================================
    // clock control fields
    localparam int FLAG_BIT = 7;
    localparam int CLEAR_BIT = 3;
    localparam int SELECT_LSB = 0;
    localparam int SELECT_MSB = 2;
    localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h05;
    localparam logic [7:0] COUNT_VALUE_RESET = 8'h00;

    // ==========================================================
    // interrupt status fields, same layout in the mask
    localparam int IRQ_INTERVAL_BIT = 0;
    localparam int IRQ_STABLE_BIT = 1;
    localparam int IRQ_BITS = 2;
    localparam logic [IRQ_BITS-1:0] IRQ_STATUS_RESET = 2'h0;
    localparam logic [IRQ_BITS-1:0] IRQ_MASK_RESET = 2'h0;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_PS = 10000;
    // one timer clock period, 0.256 ms (about 3.9 kHz)
    localparam int TIMER_CLOCK_PERIOD_PS = 256000000;
    localparam int PRESCALE_CYCLES = TIMER_CLOCK_PERIOD_PS / CLK_PERIOD_PS;
    localparam int PRESCALE_WIDTH = 16;
    // self clear of the counter clear bit, in clk cycles
    localparam int MACHINE_CYCLES = 1;

    typedef enum logic {
        st_osc_wait,
        st_running
    } osc_state_e;

endpackage

/* File: src/interval_prescaler.sv */
`timescale 1ns/100ps

module interval_prescaler
    import bit_pkg::*;
#(
    parameter int DIVIDE = PRESCALE_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic restart,
    output logic tick
);

    typedef struct packed
    {
        logic [PRESCALE_WIDTH-1:0] count;
        logic tick;
    } prescale_s;

    localparam logic [PRESCALE_WIDTH-1:0] LAST = PRESCALE_WIDTH'(DIVIDE - 1);

    prescale_s state;
    prescale_s next_state;

    // ==========================================================
    // divider to timer-clock enable
    always_comb
    begin
        next_state = state;
        next_state.tick = 1'b0;
        if (restart)
        begin
            // a full period follows a counter clear
            next_state.count = '0;
        end
        else if (state.count == LAST)
        begin
            next_state.count = '0;
            next_state.tick = 1'b1;
        end
        else
        begin
            next_state.count = state.count + PRESCALE_WIDTH'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign tick = state.tick;

endmodule

/* File: src/basic_interval_timer.sv */
`timescale 1ns/100ps

// Overview of operation
// - 8-bit up-counter runs freely on the timer clock; nothing stops it.
// - each interval event is exported as a one-cycle watchdog time base pulse.
// - interval event sets the flag and requests interrupt; writing 0 clears flag.
// - writing 1 to counter clear zeroes the count, then counting resumes.
// - counter clear bit returns to 0 by itself one machine cycle later.
// - period select doubles the interval from 0.512 ms to 65.536 ms.
// - clock control resets to 05h, period select 101, 16.384 ms.
// - oscillator-stable wait timed after reset and after leaving stop mode.
// - count register is read-only, shows the count, resets to 00h.
// - flag bit 7, bits 6-4 reserved read-only, clear bit 3, select 2-0.

module basic_interval_timer
    import bit_pkg::*;
#(
    parameter int PRESCALE = PRESCALE_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic stop_exit,
    output logic wdt_tick,
    output logic osc_stable,
    output logic irq
);

    typedef struct packed
    {
        logic [7:0] count;
        logic interval_flag;
        logic counter_clear;
        logic [SELECT_MSB:SELECT_LSB] period_select;
        logic [IRQ_BITS-1:0] status;
        logic [IRQ_BITS-1:0] mask;
        logic [7:0] rdata;
        logic wdt_tick;
        osc_state_e osc_state;
    } timer_state_s;

    timer_state_s state;
    timer_state_s next_state;

    logic timer_tick;
    logic restart;
    logic interval_event;
    logic [7:0] select_mask;
    logic wr_control;
    logic wr_status;
    logic wr_mask;
    logic [7:0] control_view;

    logic [7:0] next_count;
    logic next_flag;
    logic next_clear;
    logic [SELECT_MSB:SELECT_LSB] next_select;

    logic [IRQ_BITS-1:0] status_set;
    logic [IRQ_BITS-1:0] status_clear;
    logic [IRQ_BITS-1:0] next_mask;
    logic [IRQ_BITS-1:0] pending;

    osc_state_e next_osc;
    logic osc_done;
    logic [7:0] read_view;

    // ==========================================================
    // timer clock enable
    interval_prescaler #(
        .DIVIDE(PRESCALE)
    ) u_prescaler (
        .clk(clk),
        .rst(rst),
        .restart(restart),
        .tick(timer_tick)
    );

    // ==========================================================
    // bus decode
    always_comb
    begin
        wr_control = wr && (addr == ADDR_CLOCK_CONTROL);
        wr_status = wr && (addr == ADDR_IRQ_STATUS);
        wr_mask = wr && (addr == ADDR_IRQ_MASK);
    end

    // clear written, or stop exit, restarts the prescaler too
    always_comb
    begin
        restart = stop_exit;
        if (wr_control && wdata[CLEAR_BIT])
        begin
            restart = 1'b1;
        end
    end

    // ==========================================================
    // interval event from the count divider chain
    always_comb
    begin
        select_mask = '0;
        for (int i = 0; i < 8; i++)
        begin
            if (i <= int'(state.period_select))
            begin
                select_mask[i] = 1'b1;
            end
        end
    end

    // limitation: a select change mid-interval shortens or stretches the next one
    // low select+1 bits all ones at a tick: 2^(select+1) ticks apart
    always_comb
    begin
        interval_event = 1'b0;
        if (timer_tick && !state.counter_clear)
        begin
            interval_event = &(state.count | ~select_mask);
        end
    end

    // ==========================================================
    // read view of the clock control register
    always_comb
    begin
        control_view = '0;
        control_view[FLAG_BIT] = state.interval_flag;
        control_view[CLEAR_BIT] = state.counter_clear;
        control_view[SELECT_MSB:SELECT_LSB] = state.period_select;
    end

    // ==========================================================
    // clock control register
    always_comb
    begin
        next_flag = state.interval_flag;
        // the clear bit stands for one cycle after each write of a one
        next_clear = 1'b0;
        next_select = state.period_select;
        if (wr_control)
        begin
            // a new select leaves the count alone and applies from the next cycle
            next_select = wdata[SELECT_MSB:SELECT_LSB];
            next_clear = wdata[CLEAR_BIT];
            if (!wdata[FLAG_BIT])
            begin
                next_flag = 1'b0;
            end
        end
        if (interval_event)
        begin
            // an event in the cycle of a clearing write still sets the flag
            next_flag = 1'b1;
        end
    end

    // ==========================================================
    // counter
    always_comb
    begin
        next_count = state.count;
        // stop exit and clear also restart the prescaler, so a full tick follows
        if (stop_exit)
        begin
            next_count = '0;
        end
        else if (wr_control && wdata[CLEAR_BIT])
        begin
            next_count = '0;
        end
        else if (state.counter_clear)
        begin
            // held at zero while the clear bit stands
            next_count = '0;
        end
        else if (timer_tick)
        begin
            // wraps past ffh, nothing can hold it
            next_count = state.count + 8'h01;
        end
    end

    // ==========================================================
    // interrupt status, write one to clear
    always_comb
    begin
        // each source keeps its bit until software writes a one to it
        status_set = '0;
        status_clear = '0;
        if (wr_status)
        begin
            status_clear = wdata[IRQ_BITS-1:0];
        end
        if (interval_event)
        begin
            status_set[IRQ_INTERVAL_BIT] = 1'b1;
        end
        if (osc_done)
        begin
            status_set[IRQ_STABLE_BIT] = 1'b1;
        end
    end

    // ==========================================================
    // interrupt mask, same layout as the status
    always_comb
    begin
        next_mask = state.mask;
        if (wr_mask)
        begin
            next_mask = wdata[IRQ_BITS-1:0];
        end
    end

    // ==========================================================
    // oscillator stable wait: one full selected interval from a restart
    always_comb
    begin
        // power-on and stop exit share this wait
        next_osc = state.osc_state;
        osc_done = 1'b0;
        case (state.osc_state)
            st_osc_wait:
            begin
                // a stop exit in the event cycle starts the wait over
                if (interval_event && !stop_exit)
                begin
                    next_osc = st_running;
                    osc_done = 1'b1;
                end
            end
            st_running:
            begin
                if (stop_exit)
                begin
                    next_osc = st_osc_wait;
                end
            end
            default:
            begin
                next_osc = st_osc_wait;
            end
        endcase
    end

    // ==========================================================
    // read multiplexer; unmapped addresses read as zero
    always_comb
    begin
        read_view = '0;
        case (addr)
            ADDR_CLOCK_CONTROL:
            begin
                read_view = control_view;
            end
            ADDR_COUNT_VALUE:
            begin
                read_view = state.count;
            end
            ADDR_IRQ_STATUS:
            begin
                read_view = {{(8-IRQ_BITS){1'b0}}, state.status};
            end
            ADDR_IRQ_MASK:
            begin
                read_view = {{(8-IRQ_BITS){1'b0}}, state.mask};
            end
            default:
            begin
                read_view = '0;
            end
        endcase
    end

    // ==========================================================
    // next state
    always_comb
    begin
        next_state = state;
        next_state.count = next_count;
        next_state.interval_flag = next_flag;
        next_state.counter_clear = next_clear;
        next_state.period_select = next_select;
        // a set wins over a clear written in the same cycle
        next_state.status = (state.status & ~status_clear) | status_set;
        next_state.mask = next_mask;
        next_state.wdt_tick = interval_event;
        next_state.osc_state = next_osc;
        // read data stand only in the cycle after the strobe
        if (rd)
        begin
            next_state.rdata = read_view;
        end
        else
        begin
            next_state.rdata = '0;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state.count <= COUNT_VALUE_RESET;
            state.interval_flag <= CLOCK_CONTROL_RESET[FLAG_BIT];
            state.counter_clear <= CLOCK_CONTROL_RESET[CLEAR_BIT];
            state.period_select <= CLOCK_CONTROL_RESET[SELECT_MSB:SELECT_LSB];
            state.status <= IRQ_STATUS_RESET;
            state.mask <= IRQ_MASK_RESET;
            state.rdata <= '0;
            state.wdt_tick <= 1'b0;
            // power-on also begins with the stable wait
            state.osc_state <= st_osc_wait;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ==========================================================
    // outputs
    assign rdata = state.rdata;
    assign wdt_tick = state.wdt_tick;
    assign osc_stable = (state.osc_state == st_running);
    // level request, kept until software clears or masks every cause
    assign pending = state.status & state.mask;
    assign irq = |pending;

endmodule

/* File: tb/bit_checker.sv */
`timescale 1ns/100ps

module bit_checker
    import bit_pkg::*;
#(
    parameter int PRESCALE = PRESCALE_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic stop_exit,
    input wire logic wdt_tick,
    input wire logic osc_stable,
    input wire logic irq
);
    logic [IRQ_BITS-1:0] mask_copy;
    logic ctl_rd;
    logic clr_wr;

    assign ctl_rd = rd && addr == ADDR_CLOCK_CONTROL;
    assign clr_wr = wr && addr == ADDR_CLOCK_CONTROL && wdata[CLEAR_BIT];

    // shadow of the mask, so irq can be tied to its cause
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mask_copy <= IRQ_MASK_RESET;
        end
        else if (wr && addr == ADDR_IRQ_MASK)
        begin
            mask_copy <= wdata[IRQ_BITS-1:0];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // ==========================================================
    // properties
    reserved_zero_a: assert property (ctl_rd |=> rdata[6:4] == 3'h0)
        else $error("reserved control bits read nonzero");
    clear_seen_a: assert property (clr_wr ##1 ctl_rd |=> rdata[CLEAR_BIT])
        else $error("clear bit gone too early");
    clear_self_a: assert property (clr_wr ##1 !wr ##1 ctl_rd |=> !rdata[CLEAR_BIT])
        else $error("clear bit did not self clear");
    clear_zero_a: assert property (clr_wr ##1 (rd && addr == ADDR_COUNT_VALUE)
        |=> rdata == 8'h00)
        else $error("count not zero after clear");
    tick_gap_a: assert property (wdt_tick |=> !wdt_tick [*7])
        else $error("interval events too close");
    stable_tick_a: assert property ($rose(osc_stable) |-> wdt_tick)
        else $error("stable wait ended off an event");
    stable_drop_a: assert property (stop_exit |=> !osc_stable)
        else $error("stop exit did not restart wait");
    stable_keep_a: assert property (osc_stable && !stop_exit |=> osc_stable)
        else $error("stable indication dropped");
    irq_event_a: assert property (wdt_tick && mask_copy[IRQ_INTERVAL_BIT] |-> irq)
        else $error("unmasked event without irq");
    irq_off_a: assert property (wr && addr == ADDR_IRQ_MASK && wdata[1:0] == 2'h0
        |=> !irq)
        else $error("irq high with all masked");
    unmapped_a: assert property (rd && (addr < ADDR_CLOCK_CONTROL || addr > ADDR_IRQ_MASK)
        |=> rdata == 8'h00)
        else $error("unmapped read nonzero");

    cover property (clr_wr ##1 ctl_rd);
    cover property ($rose(osc_stable));
    cover property (wdt_tick && irq);
endmodule

bind basic_interval_timer bit_checker #(.PRESCALE(PRESCALE)) bit_checker_inst (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .stop_exit(stop_exit), .wdt_tick(wdt_tick),
    .osc_stable(osc_stable), .irq(irq)
);

/* File: tb/tb_top.sv */
`timescale 1ns/100ps

module tb_top
    import bit_pkg::*;
;
    localparam int PS = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic stop_exit = 1'b0;
    logic [7:0] rdata;
    logic wdt_tick;
    logic osc_stable;
    logic irq;
    logic [15:0] q;
    logic [2:0] s;
    int num_errors = 0;
    int cmp_count = 0;
    int c;
    int n;

    always #5 clk = ~clk;

    basic_interval_timer #(.PRESCALE(PS)) basic_interval_timer_inst (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .stop_exit(stop_exit), .wdt_tick(wdt_tick),
        .osc_stable(osc_stable), .irq(irq)
    );

    // ==========================================================
    // helpers
    function automatic int span(input logic [2:0] sel);
        return (2 << sel) * PS;
    endfunction

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one bus cycle; read data is taken just after the edge that returns it
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        #1;
        q = 16'(rdata);
    endtask

    task automatic idle(input int k);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (k) @(posedge clk);
        #1;
    endtask

    // counts edges until the next watchdog tick, bounded
    task automatic next_tick();
        wr <= 1'b0;
        rd <= 1'b0;
        c = 0;
        do
        begin
            @(posedge clk);
            #1;
            c++;
        end
        while (wdt_tick !== 1'b1 && c < 3000);
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        #500000;
        num_errors++;
        end_sim();
    end

    // ==========================================================
    // tests
    initial
    begin
        void'($urandom(32'h7147));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        xfer(1'b0, ADDR_COUNT_VALUE, 8'h00);
        chk("count_reset", q, 16'(COUNT_VALUE_RESET));
        xfer(1'b0, ADDR_CLOCK_CONTROL, 8'h00);
        chk("ctrl_reset", q, 16'(CLOCK_CONTROL_RESET));
        xfer(1'b0, ADDR_IRQ_STATUS, 8'h00);
        chk("status_reset", q, 16'(IRQ_STATUS_RESET));
        xfer(1'b0, ADDR_IRQ_MASK, 8'h00);
        chk("mask_reset", q, 16'(IRQ_MASK_RESET));
        xfer(1'b0, 8'($urandom_range(0, 138)), 8'h00);
        chk("unmapped", q, 16'h0);
        chk("stable_low", 16'(osc_stable), 16'h0);
        next_tick();
        chk("stable_wait", 16'(c + 5 >= span(5) - 3 && c + 5 <= span(5) + 3), 16'h1);
        chk("stable_high", 16'(osc_stable), 16'h1);
        xfer(1'b0, ADDR_IRQ_STATUS, 8'h00);
        chk("status_set", q, 16'h3);
        xfer(1'b0, ADDR_CLOCK_CONTROL, 8'h00);
        chk("flag_set", q, 16'h85);
        $display("reset and stable wait done");

        xfer(1'b1, ADDR_CLOCK_CONTROL, {1'b0, 3'($urandom), 4'h5});
        xfer(1'b0, ADDR_CLOCK_CONTROL, 8'h00);
        chk("flag_clear", q, 16'h05);
        xfer(1'b1, ADDR_CLOCK_CONTROL, 8'h85);
        xfer(1'b0, ADDR_CLOCK_CONTROL, 8'h00);
        chk("flag_keep", q, 16'h05);
        xfer(1'b1, ADDR_IRQ_MASK, 8'h01);
        chk("irq_unmask", 16'(irq), 16'h1);
        xfer(1'b1, ADDR_IRQ_STATUS, 8'h01);
        chk("irq_clear", 16'(irq), 16'h0);
        xfer(1'b1, ADDR_IRQ_MASK, 8'h03);
        chk("irq_stable", 16'(irq), 16'h1);
        xfer(1'b1, ADDR_IRQ_STATUS, 8'h02);
        chk("irq_none", 16'(irq), 16'h0);
        xfer(1'b1, ADDR_IRQ_MASK, 8'h01);
        next_tick();
        chk("irq_event", 16'(irq), 16'h1);
        xfer(1'b1, ADDR_IRQ_STATUS, 8'hff);
        xfer(1'b1, ADDR_IRQ_MASK, 8'h00);
        chk("irq_masked", 16'(irq), 16'h0);
        xfer(1'b0, ADDR_IRQ_STATUS, 8'h00);
        chk("status_clear", q, 16'h0);
        $display("flag and interrupt done");

        s = 3'($urandom);
        for (int i = 0; i < 8; i++)
        begin
            xfer(1'b1, ADDR_CLOCK_CONTROL, {5'h01, s});
            next_tick();
            next_tick();
            chk("period", 16'(c), 16'(span(s)));
            s = s + 3'h1;
        end
        $display("period select done");

        repeat (6)
        begin
            s = 3'($urandom);
            idle($urandom_range(1, 40));
            n = $urandom_range(0, 1);
            xfer(1'b1, ADDR_CLOCK_CONTROL, {5'h01, s});
            xfer(1'b0, n == 1 ? ADDR_CLOCK_CONTROL : ADDR_COUNT_VALUE, 8'h00);
            chk("clear_read", q & 16'h7f, n == 1 ? 16'h08 | 16'(s) : 16'h0);
            xfer(1'b0, ADDR_CLOCK_CONTROL, 8'h00);
            chk("clear_done", q & 16'h7f, 16'(s));
            xfer(1'b1, ADDR_COUNT_VALUE, 8'($urandom));
            n = $urandom_range(4, 60);
            idle(n);
            xfer(1'b0, ADDR_COUNT_VALUE, 8'h00);
            chk("count_run", 16'(q + 1 >= (n + 4) / PS && q <= (n + 4) / PS + 1), 16'h1);
        end
        $display("counter clear done");

        s = 3'($urandom);
        xfer(1'b1, ADDR_CLOCK_CONTROL, {5'h01, s});
        wr <= 1'b0;
        stop_exit <= 1'b1;
        @(posedge clk);
        #1;
        stop_exit <= 1'b0;
        chk("stop_low", 16'(osc_stable), 16'h0);
        next_tick();
        chk("stop_wait", 16'(c + 2 >= span(s) && c <= span(s) + 2), 16'h1);
        chk("stop_high", 16'(osc_stable), 16'h1);
        xfer(1'b0, ADDR_IRQ_STATUS, 8'h00);
        chk("stop_status", q & 16'h2, 16'h2);
        $display("stop exit done");
        end_sim();
    end
endmodule
